/* File: common/clock_select_pkg.sv */
// shared constants and types for the system clock source selector
package clock_select_pkg;

    // configuration word layout
    localparam int          CFG_WIDTH      = 16;
    localparam int          MODE_LSB       = 0;
    localparam int          PINFUNC_BIT    = 2;
    localparam int          CKSM_LSB       = 6;
    localparam int          SRC_LSB        = 8;
    localparam logic [15:0] CFG_ERASED     = 16'hffff;

    // primary mode field encodings
    localparam logic [1:0]  MODE_EXT_CLOCK = 2'h0;
    localparam logic [1:0]  MODE_CRYSTAL   = 2'h1;
    localparam logic [1:0]  MODE_HS_XTAL   = 2'h2;
    localparam logic [1:0]  MODE_OFF       = 2'h3;

    // initial source field encodings
    localparam logic [2:0]  CODE_FRC       = 3'h0;
    localparam logic [2:0]  CODE_FRC_PLL   = 3'h1;
    localparam logic [2:0]  CODE_PRI       = 3'h2;
    localparam logic [2:0]  CODE_PRI_PLL   = 3'h3;
    localparam logic [2:0]  CODE_SEC       = 3'h4;
    localparam logic [2:0]  CODE_LOW_POWER_INTERNAL_RC      = 3'h5;
    localparam logic [2:0]  CODE_RESERVED  = 3'h6;
    localparam logic [2:0]  CODE_FRC_DIV   = 3'h7;

    // register map, word offsets on the plain register port
    localparam int          ADDR_WIDTH     = 4;
    localparam int          DATA_WIDTH     = 16;
    localparam logic [3:0]  REG_STATUS     = 4'h0;
    localparam logic [3:0]  REG_CONTROL    = 4'h1;
    localparam logic [3:0]  REG_SWITCH     = 4'h2;

    // status field positions
    localparam int          ST_SOURCE_LSB  = 0;
    localparam int          ST_PLL         = 2;
    localparam int          ST_POSTSCALE   = 3;
    localparam int          ST_SWITCH_EN   = 4;
    localparam int          ST_MONITOR_EN  = 5;
    localparam int          ST_INVALID     = 6;
    localparam int          ST_FAILED      = 7;
    localparam int          ST_REFUSED     = 8;
    localparam int          ST_MODE_LSB    = 9;

    // reset values
    localparam logic [2:0]  POSTSCALE_RESET = 3'h1;
    localparam logic [2:0]  SWITCH_RESET    = 3'h7;

    // timing
    localparam logic [1:0]  SYNC_SETTLE     = 2'h2;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          FAIL_TIMEOUT_NS = 2000;
    localparam int          FAIL_TIMEOUT_CYCLES =
        (FAIL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SRC_PRIMARY   = 2'b00,
        SRC_SECONDARY = 2'b01,
        SRC_FAST_RC   = 2'b10,
        SRC_LOW_POWER = 2'b11
    } osc_source_t;

    typedef enum logic [1:0] {
        ST_WAIT   = 2'b00,
        ST_RUN    = 2'b01,
        ST_FAILOV = 2'b10
    } run_state_t;

    typedef struct packed {
        osc_source_t source;
        logic        pll_on;
        logic        postscale_on;
        logic        invalid;
    } clock_select_t;

    localparam clock_select_t SEL_ERASED = '{SRC_FAST_RC, 1'b0, 1'b1, 1'b0};

endpackage

/* File: logic/sync2.sv */
// two flip-flop synchroniser for levels entering from outside the clock
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // the first stage feeds only the second stage
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* File: logic/tick_postscaler.sv */
// divides a tick stream by a power of two, or passes it through
`timescale 1ns/1ps
module tick_postscaler #(
    parameter int RATIO_WIDTH = 3
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   tick_in,
    input  wire logic                   bypass,
    input  wire logic [RATIO_WIDTH-1:0] ratio,
    output logic                        tick_out
);

    localparam int CNT_WIDTH = (1 << RATIO_WIDTH) - 1;

    logic [CNT_WIDTH-1:0] count_q;
    logic [CNT_WIDTH-1:0] limit;
    logic                 wrap;

    // divide by two to the power of ratio
    assign limit = CNT_WIDTH'((1 << ratio) - 1);
    assign wrap  = (count_q >= limit);

    // counter restarts on wrap; a smaller ratio takes effect at once
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_q <= '0;
        else if (tick_in)
            count_q <= (wrap || bypass) ? '0 : count_q + 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tick_out <= 1'b0;
        else
            tick_out <= tick_in && (bypass || wrap);
    end

endmodule

/* File: logic/system_clock_source_select.sv */
// system clock source selection, postscaler and instruction clock
//
// Summary of operation
// - system clock comes from exactly one of four oscillator sources
// - 4x pll only behind primary oscillator or fast internal rc
// - fast internal rc may be slowed by a programmable divider
// - instruction cycle clock is the system clock, after the postscaler, divided by two
// - some primary modes drive the instruction clock on second pin
// - power-on source comes from mode bits 1:0 and source bits 10:8
// - erased configuration selects fast internal rc with postscaler
// - run-time switching only when upper switch/monitor bit is zero
// - fail-safe clock monitor only when both switch/monitor bits zero
// - source codes: 101 low power rc, 100 secondary, 001/000 fast rc
// - 010 primary, 011 primary with pll; high-speed crystal has no pll
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module system_clock_source_select #(
    parameter int FAIL_CYCLES = clock_select_pkg::FAIL_TIMEOUT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    input  wire logic [15:0] config_word,
    input  wire logic [3:0]  osc_inputs,
    output logic      [1:0]  active_source,
    output logic             pll_enable,
    output logic             system_tick,
    output logic             instruction_cycle_clock,
    output logic             second_oscillator_pin_out,
    output logic             second_oscillator_pin_oe,
    output logic             clock_switch_enabled,
    output logic             fail_safe_clock_monitor_enabled,
    output logic             clock_failed
);

    logic [15:0]                   cfg_sync;
    logic [3:0]                    osc_sync;
    clock_select_pkg::run_state_t  state_q;
    logic [1:0]                    settle_q;
    logic [1:0]                    primary_mode_field_q;
    logic [1:0]                    switch_monitor_field_q;
    logic                          osc_pin_function_bit_q;
    clock_select_pkg::clock_select_t sel_q;
    clock_select_pkg::clock_select_t boot_sel;
    clock_select_pkg::clock_select_t req_sel;
    logic [2:0]                    postscale_q;
    logic [2:0]                    switch_code_q;
    logic                          refused_q;
    logic                          src_prev_q;
    logic                          src_level;
    logic                          src_rise;
    logic [7:0]                    watch_q;
    logic                          timeout;
    logic                          load_now;
    logic                          switch_wr;
    logic                          switch_ok;
    logic                          icc_q;
    logic                          pin_oe_q;
    logic                          post_tick;

    // decodes a primary mode and source code into one source selection
    function automatic clock_select_pkg::clock_select_t decode_sel(
        input logic [1:0] mode,
        input logic [2:0] code
    );
        clock_select_pkg::clock_select_t s;
        s = '{clock_select_pkg::SRC_FAST_RC, 1'b0, 1'b0, 1'b0};
        case (code)
            clock_select_pkg::CODE_FRC:
                s.source = clock_select_pkg::SRC_FAST_RC;
            clock_select_pkg::CODE_FRC_PLL:
                s.pll_on = 1'b1;
            clock_select_pkg::CODE_PRI:
            begin
                // primary disabled: fall back to fast rc, flag it
                if (mode == clock_select_pkg::MODE_OFF)
                    s.invalid = 1'b1;
                else
                    s.source = clock_select_pkg::SRC_PRIMARY;
            end
            clock_select_pkg::CODE_PRI_PLL:
            begin
                if (mode == clock_select_pkg::MODE_OFF)
                    s.invalid = 1'b1;
                else
                begin
                    s.source  = clock_select_pkg::SRC_PRIMARY;
                    s.pll_on  = (mode != clock_select_pkg::MODE_HS_XTAL);
                    s.invalid = (mode == clock_select_pkg::MODE_HS_XTAL);
                end
            end
            clock_select_pkg::CODE_SEC:
                s.source = clock_select_pkg::SRC_SECONDARY;
            clock_select_pkg::CODE_LOW_POWER_INTERNAL_RC:
                s.source = clock_select_pkg::SRC_LOW_POWER;
            clock_select_pkg::CODE_RESERVED:
                s.invalid = 1'b1;
            default:
                s.postscale_on = 1'b1;
        endcase
        return s;
    endfunction

    // configuration word and oscillator levels come from outside the clock
    sync2 #(
        .WIDTH (16)
    ) u_cfg_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (config_word),
        .sync_out (cfg_sync)
    );

    sync2 #(
        .WIDTH (4)
    ) u_osc_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (osc_inputs),
        .sync_out (osc_sync)
    );

    assign boot_sel = decode_sel(
        cfg_sync[clock_select_pkg::MODE_LSB +: 2],
        cfg_sync[clock_select_pkg::SRC_LSB +: 3]);
    assign req_sel   = decode_sel(primary_mode_field_q, reg_wdata[2:0]);
    assign load_now  = (state_q == clock_select_pkg::ST_WAIT) &&
                       (settle_q == clock_select_pkg::SYNC_SETTLE);
    assign switch_wr = reg_write && (reg_addr == clock_select_pkg::REG_SWITCH);
    assign switch_ok = switch_wr && clock_switch_enabled &&
                       (state_q == clock_select_pkg::ST_RUN);

    // settle counter lets the synchroniser fill before capture
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            settle_q <= 2'h0;
        else if (state_q == clock_select_pkg::ST_WAIT && !load_now)
            settle_q <= settle_q + 2'h1;
    end

    // run state: wait for capture, run, or failed over to fast rc
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state_q <= clock_select_pkg::ST_WAIT;
        else
        begin
            case (state_q)
                clock_select_pkg::ST_WAIT:
                    if (load_now)
                        state_q <= clock_select_pkg::ST_RUN;
                clock_select_pkg::ST_RUN:
                    if (timeout)
                        state_q <= clock_select_pkg::ST_FAILOV;
                clock_select_pkg::ST_FAILOV:
                    state_q <= clock_select_pkg::ST_FAILOV;
                default:
                    state_q <= clock_select_pkg::ST_WAIT;
            endcase
        end
    end

    // configuration fields are frozen once, at the end of power-on reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            primary_mode_field_q   <= 2'h3;
            switch_monitor_field_q <= 2'h3;
            osc_pin_function_bit_q <= 1'b1;
        end
        else if (load_now)
        begin
            primary_mode_field_q   <= cfg_sync[clock_select_pkg::MODE_LSB +: 2];
            switch_monitor_field_q <= cfg_sync[clock_select_pkg::CKSM_LSB +: 2];
            osc_pin_function_bit_q <= cfg_sync[clock_select_pkg::PINFUNC_BIT];
        end
    end

    // exactly one source is selected at any time
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sel_q <= clock_select_pkg::SEL_ERASED;
        else if (load_now)
            sel_q <= boot_sel;
        else if (timeout)
            sel_q <= '{clock_select_pkg::SRC_FAST_RC, 1'b0, 1'b0, 1'b0};
        else if (switch_ok)
            sel_q <= req_sel;
    end

    assign clock_switch_enabled = !switch_monitor_field_q[1];
    assign fail_safe_clock_monitor_enabled =
        (switch_monitor_field_q == 2'h0);

    // rising edges of the selected, synchronised oscillator level
    assign src_level = osc_sync[sel_q.source];
    assign src_rise  = src_level && !src_prev_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            src_prev_q <= 1'b0;
        else
            src_prev_q <= src_level;
    end

    // monitor: a source that stops toggling forces fast rc
    assign timeout = fail_safe_clock_monitor_enabled &&
                     (state_q == clock_select_pkg::ST_RUN) && !src_rise &&
                     (sel_q.source != clock_select_pkg::SRC_FAST_RC) &&
                     (watch_q == 8'(FAIL_CYCLES - 1));

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            watch_q <= 8'h00;
        else if (src_rise || switch_ok || state_q != clock_select_pkg::ST_RUN)
            watch_q <= 8'h00;
        else if (!timeout)
            watch_q <= watch_q + 8'h01;
    end

    // postscaler acts only while fast rc with divider is selected
    tick_postscaler #(
        .RATIO_WIDTH (3)
    ) u_postscaler (
        .clock    (clock),
        .rst      (rst),
        .tick_in  (src_rise),
        .bypass   (!sel_q.postscale_on),
        .ratio    (postscale_q),
        .tick_out (post_tick)
    );

    assign system_tick = post_tick;

    // instruction clock toggles per system tick, giving half the rate
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            icc_q <= 1'b0;
        else if (post_tick)
            icc_q <= !icc_q;
    end

    assign instruction_cycle_clock = icc_q;

    // crystal modes need the second pin for the crystal; never drive it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pin_oe_q <= 1'b0;
        else
            pin_oe_q <= (state_q != clock_select_pkg::ST_WAIT) &&
                        osc_pin_function_bit_q &&
                        (primary_mode_field_q == clock_select_pkg::MODE_OFF ||
                         primary_mode_field_q ==
                         clock_select_pkg::MODE_EXT_CLOCK);
    end

    assign second_oscillator_pin_oe  = pin_oe_q;
    assign second_oscillator_pin_out = icc_q;

    assign active_source = sel_q.source;
    assign pll_enable    = sel_q.pll_on;
    assign clock_failed  = (state_q == clock_select_pkg::ST_FAILOV);

    // postscaler ratio and last requested source code
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            postscale_q   <= clock_select_pkg::POSTSCALE_RESET;
            switch_code_q <= clock_select_pkg::SWITCH_RESET;
        end
        else
        begin
            if (reg_write && reg_addr == clock_select_pkg::REG_CONTROL)
                postscale_q <= reg_wdata[2:0];
            if (switch_wr)
                switch_code_q <= reg_wdata[2:0];
        end
    end

    // refused flag: a new refusal wins over a write-one clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            refused_q <= 1'b0;
        else if (switch_wr && !switch_ok)
            refused_q <= 1'b1;
        else if (reg_write && reg_addr == clock_select_pkg::REG_STATUS &&
                 reg_wdata[clock_select_pkg::ST_REFUSED])
            refused_q <= 1'b0;
    end

    // read data stands one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (reg_read)
        begin
            case (reg_addr)
                clock_select_pkg::REG_STATUS:
                    reg_rdata <= {5'h00, primary_mode_field_q, refused_q,
                                  clock_failed, sel_q.invalid,
                                  fail_safe_clock_monitor_enabled,
                                  clock_switch_enabled, sel_q.postscale_on,
                                  sel_q.pll_on, sel_q.source};
                clock_select_pkg::REG_CONTROL:
                    reg_rdata <= {13'h0000, postscale_q};
                clock_select_pkg::REG_SWITCH:
                    reg_rdata <= {13'h0000, switch_code_q};
                default:
                    reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    // checks on the selection and derived clocks
    sequence seq_refused_write;
        switch_wr && !clock_switch_enabled;
    endsequence

    sequence seq_capture;
        load_now ##1 (state_q == clock_select_pkg::ST_RUN);
    endsequence

    AST_PLL_SOURCE: assert property (@(posedge clock) disable iff (rst)
        pll_enable |-> (active_source == clock_select_pkg::SRC_PRIMARY ||
                        active_source == clock_select_pkg::SRC_FAST_RC))
        else $error("pll enabled behind a source without pll");

    AST_POSTSCALE_FRC: assert property (@(posedge clock) disable iff (rst)
        sel_q.postscale_on |-> active_source == clock_select_pkg::SRC_FAST_RC)
        else $error("postscaler active on a source other than fast rc");

    AST_ICC_TOGGLE: assert property (@(posedge clock) disable iff (rst)
        system_tick |=> instruction_cycle_clock != $past(instruction_cycle_clock))
        else $error("instruction clock missed a toggle");

    AST_ICC_HOLD: assert property (@(posedge clock) disable iff (rst)
        !system_tick |=> $stable(instruction_cycle_clock))
        else $error("instruction clock toggled without a tick");

    AST_PIN_NO_XTAL: assert property (@(posedge clock) disable iff (rst)
        (state_q == clock_select_pkg::ST_RUN &&
         primary_mode_field_q == clock_select_pkg::MODE_CRYSTAL)
        |=> !second_oscillator_pin_oe)
        else $error("second pin driven in a crystal mode");

    AST_BOOT_CAPTURE: assert property (@(posedge clock) disable iff (rst)
        seq_capture |-> sel_q == $past(boot_sel) ||
                        $past(switch_ok) || $past(timeout))
        else $error("power-on selection not taken from configuration");

    AST_ERASED_DEFAULT: assert property (@(posedge clock) disable iff (rst)
        (state_q == clock_select_pkg::ST_WAIT) |->
        sel_q == clock_select_pkg::SEL_ERASED)
        else $error("reset selection is not fast rc with postscaler");

    AST_SWITCH_BIT: assert property (@(posedge clock) disable iff (rst)
        (switch_ok && !timeout) |=> sel_q == $past(req_sel))
        else $error("enabled switch request not taken");

    AST_MONITOR_FAIL: assert property (@(posedge clock) disable iff (rst)
        timeout |=> clock_failed &&
        active_source == clock_select_pkg::SRC_FAST_RC &&
        fail_safe_clock_monitor_enabled)
        else $error("monitor failover did not reach fast rc");

    AST_NO_FAIL_DISABLED: assert property (@(posedge clock) disable iff (rst)
        !fail_safe_clock_monitor_enabled |-> !clock_failed)
        else $error("failover while monitor disabled");

    AST_REFUSE_SWITCH: assert property (@(posedge clock) disable iff (rst)
        seq_refused_write |=> $stable(sel_q) && refused_q)
        else $error("switch request honoured while switching disabled");

endmodule

/* File: tb/osc_source_model.sv */
// oscillator sources seen on the selector's input pins
`timescale 1ns/1ps
module osc_source_model (
    input  wire logic       clock,
    input  wire logic       halt_primary,
    output logic      [3:0] osc_inputs = 4'h0
);
    int cnt [4] = '{0, 0, 0, 0};
    // half periods of at least two cycles, shorter pulses would be missed
    int half [4] = '{3, 4, 2, 5};
    // each source toggles after its own half period; a dead crystal rests low
    always @(posedge clock)
    begin
        for (int i = 0; i < 4; i++)
        begin
            cnt[i] <= (cnt[i] + 1 == half[i]) ? 0 : cnt[i] + 1;
            if (cnt[i] + 1 == half[i])
                osc_inputs[i] <= ~osc_inputs[i];
        end
        if (halt_primary)
            osc_inputs[0] <= 1'b0;
    end
endmodule

/* File: tb/system_clock_source_select_tb.sv */
// self-checking bench for the system clock source selector
`timescale 1ns/1ps
module system_clock_source_select_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [15:0] config_word = 16'hffff;
    logic        halt = 1'b0;
    logic        tick_seen = 1'b0;
    logic        icc_seen = 1'b0;
    wire  [15:0] reg_rdata;
    wire  [3:0]  osc_inputs;
    wire  [1:0]  active_source;
    wire         pll_enable, system_tick, icc, pin_out, pin_oe;
    wire         switch_en, monitor_en, clock_failed;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          ticks = 0;
    always #12.5 clock = ~clock;
    osc_source_model i_osc (.clock(clock), .halt_primary(halt),
        .osc_inputs(osc_inputs));
    // small failure count keeps the monitor scenario short
    system_clock_source_select #(.FAIL_CYCLES(8)) i_dut (.clock(clock),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .config_word(config_word), .osc_inputs(osc_inputs),
        .active_source(active_source), .pll_enable(pll_enable),
        .system_tick(system_tick), .instruction_cycle_clock(icc),
        .second_oscillator_pin_out(pin_out),
        .second_oscillator_pin_oe(pin_oe), .clock_switch_enabled(switch_en),
        .fail_safe_clock_monitor_enabled(monitor_en),
        .clock_failed(clock_failed));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // status word the configuration should produce right after boot
    function automatic logic [15:0] want_status(input logic [15:0] cw);
        logic [1:0] m;
        logic [2:0] c;
        logic [1:0] s;
        logic       p;
        logic       ps;
        logic       inv;
        m = cw[1:0];
        c = cw[10:8];
        s = 2'h2;
        p = 1'b0;
        ps = 1'b0;
        inv = 1'b0;
        case (c)
            3'h1: p = 1'b1;
            3'h2, 3'h3:
                if (m == 2'h3)
                    inv = 1'b1;
                else
                begin
                    s = 2'h0;
                    p = (c == 3'h3) && (m != 2'h2);
                    inv = (c == 3'h3) && (m == 2'h2);
                end
            3'h4: s = 2'h1;
            3'h5: s = 2'h3;
            3'h6: inv = 1'b1;
            3'h7: ps = 1'b1;
            default: ;
        endcase
        return {5'h0, m, 2'h0, inv, cw[7:6] == 2'h0, ~cw[7], ps, p, s};
    endfunction
    task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // config must be settled before reset lets go, it is captured once
    task automatic boot(input logic [15:0] cw);
        config_word <= cw;
        rst <= 1'b1;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
    // tick counter, instruction clock and pin watch, hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            errors++;
            summarize();
        end
        if (system_tick === 1'b1)
            ticks++;
        if (tick_seen && !rst)
            check(icc, !icc_seen);
        if (pin_oe === 1'b1 && !rst)
            check(pin_out, icc);
        tick_seen <= system_tick;
        icc_seen <= icc;
    end
    initial
    begin
        logic [15:0] cw;
        logic [15:0] w;
        logic [15:0] rd;
        void'($urandom(57005));
        boot(16'hffff);
        bus_read(4'h0, rd);
        check(rd, want_status(16'hffff));
        bus_read(4'hf, rd);
        check(rd, 16'h0);
        bus_read(4'h1, rd);
        check(rd, 16'h1);
        // every mode and source code, random switch/monitor and pin bits
        for (int i = 0; i < 32; i++)
        begin
            cw = 16'h0;
            cw[1:0] = i[1:0];
            cw[10:8] = i[4:2];
            cw[7:6] = 2'($urandom);
            cw[2] = 1'($urandom);
            w = want_status(cw);
            boot(cw);
            bus_read(4'h0, rd);
            check(rd, w);
            check({monitor_en, switch_en, pll_enable, active_source},
                {w[5], w[4], w[2], w[1:0]});
            check(pin_oe, cw[2] && (cw[1:0] == 2'h3 || cw[1:0] == 2'h0));
        end
        // tick rate of plain fast rc, then with the postscaler
        boot(16'h00c3);
        ticks = 0;
        repeat (200) @(posedge clock);
        check(ticks >= 49 && ticks <= 51, 1'b1);
        boot(16'h07c3);
        ticks = 0;
        repeat (200) @(posedge clock);
        check(ticks >= 24 && ticks <= 26, 1'b1);
        bus_write(4'h1, 16'h0);
        ticks = 0;
        repeat (200) @(posedge clock);
        check(ticks >= 49 && ticks <= 51, 1'b1);
        // switching allowed, then refused when the field forbids it
        boot(16'h0043);
        bus_write(4'h2, 16'h5);
        @(posedge clock);
        #1 check(active_source, 2'h3);
        boot(16'h00c3);
        bus_write(4'h2, 16'h4);
        @(posedge clock);
        #1 check(active_source, 2'h2);
        bus_read(4'h0, rd);
        check(rd[8], 1'b1);
        // dead primary external clock with the monitor on falls back to fast rc
        boot(16'h0200);
        #1 check({clock_failed, active_source}, 3'h0);
        halt <= 1'b1;
        repeat (30) @(posedge clock);
        check({clock_failed, pll_enable, active_source}, 4'ha);
        halt <= 1'b0;
        summarize();
    end
endmodule
